// ### verilog/wake_frame_pattern_matcher.sv
// How it works
// - Descriptor byte: upper nibble skip, lower nibble length, 0..14 direct.
// - Nibble 15 means the real 8-bit value is in the next byte.
// - Both nibbles 15: next byte is skip, the one after is length.
// - Descriptor byte 0x00 ends the descriptor list of a set.
// - Ethernet CRC runs over selected frame bytes, compared with stored.
// - Expected CRC follows the end marker, least significant byte first.
// - Per descriptor, skip the skip count, then include length bytes.
// - CRC equality raises a wake event; rare false matches accepted.
// - Next set starts right after the previous CRC; sets run independently.
// - Six consecutive 0xFF bytes open the wake sequence.
// - Then sixteen back-to-back copies of the station address match.
// - The sequence may sit anywhere in a frame for this station.
// - Host register block spans 128 bytes in I/O or memory space.
`timescale 1ns/1ns
module wake_frame_pattern_matcher #(
  parameter int NSETS = 4,
  parameter int DEPTH = 128
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic pattern_en_i,
  input wire logic wake_frame_en_i,
  input wire logic [47:0] station_addr_i,
  input wire logic desc_clear_i,
  input wire logic desc_wr_i,
  input wire logic [7:0] desc_data_i,
  input wire logic desc_commit_i,
  input wire logic rx_start_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_end_i,
  input wire logic rx_for_station_i,
  output logic desc_ready_o,
  output logic [NSETS-1:0] pattern_match_o,
  output logic wake_frame_o,
  output logic wake_event_o
);

  localparam int AW = $clog2(DEPTH);
  localparam int SW = $clog2(NSETS) + 1;
  localparam logic [AW:0] DEPTH_W = (AW + 1)'(DEPTH);
  localparam logic [SW-1:0] NSETS_W = SW'(NSETS);

  logic [7:0] mem [DEPTH];
  logic [AW:0] fill_r;

  // Unwritten locations read as an end marker, so a truncated load ends
  function automatic logic [7:0] rd(input logic [AW:0] a, input logic [2:0] o);
    logic [AW:0] x;
    x = a + (AW + 1)'(o);
    return (x < fill_r) ? mem[x[AW-1:0]] : wake_pkg::DESC_END;
  endfunction : rd

  function automatic wake_pkg::desc_t dec_at(input logic [AW:0] a);
    return wake_pkg::desc_decode(rd(a, 3'h0), rd(a, 3'h1), rd(a, 3'h2));
  endfunction : dec_at

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor store, appended in order; the parent maps it into the
  // host window of wake_pkg::HOST_WINDOW_BYTES bytes
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      fill_r <= '0;
    end else if (ce_i) begin
      if (desc_clear_i) begin
        fill_r <= '0;
      end else if (desc_wr_i && fill_r < DEPTH_W) begin
        fill_r <= fill_r + (AW + 1)'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (ce_i && !desc_clear_i && desc_wr_i && fill_r < DEPTH_W) begin
      mem[fill_r[AW-1:0]] <= desc_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scanner finds where each set starts after a commit
  logic scan_busy_r;
  logic [AW:0] scan_ptr_r;
  logic [AW:0] scan_start_r;
  logic [SW-1:0] scan_set_r;
  logic [AW:0] base_r [NSETS];
  logic [NSETS-1:0] set_ok_r;
  wake_pkg::desc_t scan_d;

  assign scan_d = dec_at(scan_ptr_r);

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      scan_busy_r <= 1'b0;
      scan_ptr_r <= '0;
      scan_start_r <= '0;
      scan_set_r <= '0;
      set_ok_r <= '0;
      desc_ready_o <= 1'b0;
      for (int k = 0; k < NSETS; k++) begin
        base_r[k] <= '0;
      end
    end else if (ce_i) begin
      if (desc_clear_i || desc_commit_i) begin
        scan_busy_r <= desc_commit_i && !desc_clear_i;
        scan_ptr_r <= '0;
        scan_start_r <= '0;
        scan_set_r <= '0;
        set_ok_r <= '0;
        desc_ready_o <= 1'b0;
      end else if (scan_busy_r) begin
        if (scan_ptr_r >= fill_r || scan_set_r == NSETS_W) begin
          scan_busy_r <= 1'b0;
          desc_ready_o <= 1'b1;
        end else if (scan_d.end_f) begin
          // A set counts only when its whole CRC has been loaded
          if (scan_ptr_r + (AW + 1)'(wake_pkg::CRC_OFS_3) < fill_r) begin
            set_ok_r[scan_set_r[SW-2:0]] <= 1'b1;
            base_r[scan_set_r[SW-2:0]] <= scan_start_r;
          end
          scan_ptr_r <= scan_ptr_r + (AW + 1)'(wake_pkg::NEXT_SET_OFS);
          scan_start_r <= scan_ptr_r + (AW + 1)'(wake_pkg::NEXT_SET_OFS);
          scan_set_r <= scan_set_r + SW'(1);
        end else begin
          scan_ptr_r <= scan_ptr_r + (AW + 1)'(scan_d.size);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One evaluator per set; all watch the same frame bytes
  logic [NSETS-1:0] hit_c;

  for (genvar k = 0; k < NSETS; k++) begin : g_set
    wake_pkg::eval_state_t st_r;
    logic act_r;
    logic [AW:0] ptr_r;
    logic [7:0] skip_r;
    logic [7:0] len_r;
    logic [1:0] size_r;
    logic [31:0] crc_r;
    wake_pkg::desc_t d;
    logic [7:0] cur_skip;
    logic [7:0] cur_len;
    logic [1:0] cur_size;
    logic fin;
    logic [31:0] exp_crc;

    assign d = dec_at(ptr_r);
    assign cur_skip = act_r ? skip_r : d.skip;
    assign cur_len = act_r ? len_r : d.len;
    assign cur_size = act_r ? size_r : d.size;
    assign fin = (st_r == wake_pkg::EV_DONE)
      || (st_r == wake_pkg::EV_RUN && !act_r && d.end_f);
    assign exp_crc = {rd(ptr_r, wake_pkg::CRC_OFS_3),
      rd(ptr_r, wake_pkg::CRC_OFS_2), rd(ptr_r, wake_pkg::CRC_OFS_1),
      rd(ptr_r, wake_pkg::CRC_OFS_0)};
    assign hit_c[k] = rx_end_i && pattern_en_i && fin
      && (~crc_r == exp_crc);

    always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
        st_r <= wake_pkg::EV_IDLE;
        act_r <= 1'b0;
        ptr_r <= '0;
        skip_r <= '0;
        len_r <= '0;
        size_r <= '0;
        crc_r <= wake_pkg::CRC_INIT;
      end else if (ce_i) begin
        if (rx_start_i) begin
          st_r <= (set_ok_r[k] && desc_ready_o && pattern_en_i)
            ? wake_pkg::EV_RUN : wake_pkg::EV_IDLE;
          act_r <= 1'b0;
          ptr_r <= base_r[k];
          crc_r <= wake_pkg::CRC_INIT;
        end else if (rx_end_i) begin
          st_r <= wake_pkg::EV_IDLE;
        end else if (st_r == wake_pkg::EV_RUN) begin
          if (!act_r && d.end_f) begin
            st_r <= wake_pkg::EV_DONE;
          end else if (act_r && skip_r == 8'h00 && len_r == 8'h00) begin
            ptr_r <= ptr_r + (AW + 1)'(size_r);
            act_r <= 1'b0;
          end else if (rx_valid_i) begin
            if (cur_skip != 8'h00) begin
              skip_r <= cur_skip - 8'h01;
              len_r <= cur_len;
              size_r <= cur_size;
              act_r <= 1'b1;
            end else if (cur_len != 8'h00) begin
              crc_r <= wake_pkg::crc_byte(crc_r, rx_data_i);
              skip_r <= 8'h00;
              len_r <= cur_len - 8'h01;
              size_r <= cur_size;
              act_r <= (cur_len != 8'h01);
              if (cur_len == 8'h01) begin
                ptr_r <= ptr_r + (AW + 1)'(cur_size);
              end
            end else begin
              // Empty descriptor eats this byte; leave a gap after one
              ptr_r <= ptr_r + (AW + 1)'(cur_size);
              act_r <= 1'b0;
            end
          end
        end
      end
    end

    sequence s_short_end;
      ce_i && rx_end_i && !rx_start_i && !fin;
    endsequence

    a_short_no_match: assert property (@(posedge sys_clk_i)
      disable iff (!rstn_i) s_short_end |=> !pattern_match_o[k])
      else $error("match reported for an unfinished set");

    a_match_crc_equal: assert property (@(posedge sys_clk_i)
      disable iff (!rstn_i) pattern_match_o[k] |-> $past(fin)
        && $past(~crc_r) == $past(exp_crc) && $past(rx_end_i))
      else $error("match reported with unequal CRC");

    a_skip_holds_crc: assert property (@(posedge sys_clk_i)
      disable iff (!rstn_i) ce_i && rx_valid_i && !rx_start_i && !rx_end_i
        && st_r == wake_pkg::EV_RUN && act_r && skip_r != 8'h00
        |=> $stable(crc_r) && len_r == $past(len_r))
      else $error("skipped byte changed the CRC");
  end

  ////////////////////////////////////////////////////////////////////////////
  a_ext_both_size: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) ce_i && scan_busy_r && !desc_clear_i
      && !desc_commit_i && scan_ptr_r < fill_r && scan_set_r != NSETS_W
      && rd(scan_ptr_r, 3'h0) == 8'hFF
      |=> scan_ptr_r == $past(scan_ptr_r) + (AW + 1)'(3))
    else $error("double extended descriptor not three bytes");

  a_end_next_set: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) ce_i && scan_busy_r && !desc_clear_i
      && !desc_commit_i && scan_ptr_r < fill_r && scan_set_r != NSETS_W
      && scan_d.end_f
      |=> scan_start_r == $past(scan_ptr_r) + (AW + 1)'(5))
    else $error("next set does not follow the CRC");

  ////////////////////////////////////////////////////////////////////////////
  logic wf_hit;

  wake_sync_detector u_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .enable_i(wake_frame_en_i),
    .station_addr_i(station_addr_i),
    .rx_start_i(rx_start_i),
    .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i),
    .rx_end_i(rx_end_i),
    .rx_for_station_i(rx_for_station_i),
    .hit_o(wf_hit)
  );

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      pattern_match_o <= '0;
      wake_frame_o <= 1'b0;
      wake_event_o <= 1'b0;
    end else if (ce_i) begin
      pattern_match_o <= hit_c;
      wake_frame_o <= wf_hit;
      wake_event_o <= (|hit_c) || wf_hit;
    end
  end

  a_event_from_match: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) ce_i && (|hit_c) |=> wake_event_o
      && pattern_match_o == $past(hit_c))
    else $error("pattern match did not raise wake event");

  a_event_from_wake: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) ce_i && wf_hit |=> wake_frame_o && wake_event_o)
    else $error("wake frame did not raise wake event");

endmodule : wake_frame_pattern_matcher

// ### verilog/wake_pkg.sv
package wake_pkg;

  // Descriptor byte coding
  localparam logic [7:0] DESC_END = 8'h00;
  localparam logic [3:0] NIB_EXT = 4'hF;
  localparam int NIB_HI = 4;
  localparam logic [1:0] SIZE_ONE = 2'h1;

  // Host register window that contains this block
  localparam int HOST_WINDOW_BYTES = 128;

  // Expected CRC sits just after the end marker
  localparam logic [2:0] CRC_OFS_0 = 3'h1;
  localparam logic [2:0] CRC_OFS_1 = 3'h2;
  localparam logic [2:0] CRC_OFS_2 = 3'h3;
  localparam logic [2:0] CRC_OFS_3 = 3'h4;
  localparam logic [2:0] NEXT_SET_OFS = 3'h5;

  // Ethernet frame check sequence, reflected form
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;

  // Wake frame layout
  localparam logic [7:0] PREFIX_BYTE = 8'hFF;
  localparam logic [2:0] PREFIX_LAST = 3'h5;
  localparam logic [2:0] ADDR_LAST = 3'h5;
  localparam logic [3:0] REPEAT_LAST = 4'hF;

  typedef enum logic [1:0] {
    EV_IDLE = 2'b00,
    EV_RUN = 2'b01,
    EV_DONE = 2'b10
  } eval_state_t;

  typedef struct packed {
    logic end_f;
    logic [7:0] skip;
    logic [7:0] len;
    logic [1:0] size;
  } desc_t;

  function automatic desc_t desc_decode(input logic [7:0] b0,
                                        input logic [7:0] b1,
                                        input logic [7:0] b2);
    desc_t d;
    logic hi_ext;
    logic lo_ext;
    hi_ext = (b0[7:4] == NIB_EXT);
    lo_ext = (b0[3:0] == NIB_EXT);
    d.end_f = (b0 == DESC_END);
    d.skip = hi_ext ? b1 : {4'h0, b0[7:4]};
    d.len = lo_ext ? (hi_ext ? b2 : b1) : {4'h0, b0[3:0]};
    d.size = SIZE_ONE + {1'b0, hi_ext} + {1'b0, lo_ext};
    return d;
  endfunction : desc_decode

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

endpackage : wake_pkg

// ### verilog/wake_sync_detector.sv
`timescale 1ns/1ns
module wake_sync_detector (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic [47:0] station_addr_i,
  input wire logic rx_start_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_end_i,
  input wire logic rx_for_station_i,
  output logic hit_o
);

  logic [2:0] ff_cnt_r;
  logic in_addr_r;
  logic [2:0] pos_r;
  logic [3:0] rep_r;
  logic seen_r;
  logic [7:0] exp_byte;
  logic is_sync;

  // First address byte on the wire is the top byte
  assign exp_byte = station_addr_i[8 * (wake_pkg::ADDR_LAST - pos_r) +: 8];
  assign is_sync = (rx_data_i == wake_pkg::PREFIX_BYTE);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || (ce_i && rx_start_i)) begin
      ff_cnt_r <= 3'h0;
      in_addr_r <= 1'b0;
      pos_r <= 3'h0;
      rep_r <= 4'h0;
      seen_r <= 1'b0;
    end else if (ce_i && rx_valid_i && !seen_r) begin
      if (in_addr_r) begin
        if (rx_data_i == exp_byte) begin
          if (pos_r == wake_pkg::ADDR_LAST) begin
            pos_r <= 3'h0;
            if (rep_r == wake_pkg::REPEAT_LAST) begin
              seen_r <= 1'b1;
              in_addr_r <= 1'b0;
            end else begin
              rep_r <= rep_r + 4'h1;
            end
          end else begin
            pos_r <= pos_r + 3'h1;
          end
        end else if (!(is_sync && pos_r == 3'h0 && rep_r == 4'h0)) begin
          // A longer run of sync bytes stays armed; others start over
          in_addr_r <= 1'b0;
          ff_cnt_r <= is_sync ? 3'h1 : 3'h0;
        end
      end else if (is_sync) begin
        if (ff_cnt_r == wake_pkg::PREFIX_LAST) begin
          in_addr_r <= 1'b1;
          pos_r <= 3'h0;
          rep_r <= 4'h0;
          ff_cnt_r <= 3'h0;
        end else begin
          ff_cnt_r <= ff_cnt_r + 3'h1;
        end
      end else begin
        ff_cnt_r <= 3'h0;
      end
    end
  end

  // Left unregistered so the parent reports it with the pattern matches
  assign hit_o = rx_end_i && seen_r && rx_for_station_i && enable_i;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_last_copy;
    ce_i && rx_valid_i && in_addr_r && !rx_start_i && rx_data_i == exp_byte
      && pos_r == wake_pkg::ADDR_LAST && rep_r == wake_pkg::REPEAT_LAST;
  endsequence

  a_seen_after_copies: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) $rose(seen_r) |-> $past(in_addr_r)
      && $past(rep_r) == wake_pkg::REPEAT_LAST)
    else $error("wake sequence seen without sixteen copies");

  a_last_copy_seen: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) s_last_copy |=> seen_r)
    else $error("sixteenth address copy not recognised");

  a_sixth_sync_arms: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) ce_i && rx_valid_i && !rx_start_i && !seen_r
      && !in_addr_r && is_sync && ff_cnt_r == wake_pkg::PREFIX_LAST
      |=> in_addr_r && pos_r == 3'h0 && rep_r == 4'h0)
    else $error("six sync bytes did not arm address match");

  a_mismatch_restarts: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) ce_i && rx_valid_i && !rx_start_i && in_addr_r
      && rx_data_i != exp_byte && !is_sync |=> !in_addr_r && ff_cnt_r == 3'h0)
    else $error("address mismatch did not restart search");

  a_hit_needs_seen: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) hit_o |-> seen_r && !in_addr_r && rx_end_i
      && rx_for_station_i)
    else $error("wake frame reported without full sequence");

endmodule : wake_sync_detector

// ### test/frame_source.sv
`timescale 1ns/1ns
module frame_source (
  input wire logic sys_clk_i,
  output logic rx_start_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_end_o
);
  logic [7:0] fifo_q[$];

  initial begin
    rx_start_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o = 8'hA5;
    rx_end_o = 1'b0;
  end

  task automatic push(input logic [7:0] b);
    fifo_q.push_back(b);
  endtask : push

  // Idle data line keeps changing so a stale byte is never mistaken as valid
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      #5;
      rx_valid_o = 1'b0;
      rx_start_o = 1'b0;
      rx_end_o = 1'b0;
      rx_data_o = ~rx_data_o + 8'h3C;
    end
  endtask : idle

  task automatic send(input int gap);
    @(posedge sys_clk_i);
    #5;
    rx_start_o = 1'b1;
    idle(1);
    while (fifo_q.size() > 0) begin
      rx_valid_o = 1'b1;
      rx_data_o = fifo_q.pop_front();
      idle(1 + gap);
    end
    // Quiet cycles let every set walk to its end marker
    idle(4);
    rx_end_o = 1'b1;
    idle(1);
  endtask : send
endmodule : frame_source

// ### test/wake_frame_pattern_matcher_tb.sv
`timescale 1ns/1ns
module wake_frame_pattern_matcher_tb;
  localparam int NSETS = 4;
  localparam logic [47:0] STATION = 48'h0A1B2C3D4E5F;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic pattern_en_i = 1'b1;
  logic wake_frame_en_i = 1'b0;
  logic desc_clear_i = 1'b0;
  logic desc_wr_i = 1'b0;
  logic [7:0] desc_data_i = 8'h00;
  logic desc_commit_i = 1'b0;
  logic rx_for_station_i = 1'b1;
  logic rx_start, rx_valid, rx_end;
  logic [7:0] rx_data;
  logic desc_ready_o, wake_frame_o, wake_event_o;
  logic [NSETS-1:0] pattern_match_o;
  logic [7:0] frm[$];
  logic [7:0] pick[$];
  logic [31:0] c0, c1, c2, c3;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;

  always #25 sys_clk_i = ~sys_clk_i;

  wake_frame_pattern_matcher #(.NSETS(NSETS), .DEPTH(128)) u_wake_frame_pattern_matcher (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .pattern_en_i(pattern_en_i), .wake_frame_en_i(wake_frame_en_i),
    .station_addr_i(STATION), .desc_clear_i(desc_clear_i),
    .desc_wr_i(desc_wr_i), .desc_data_i(desc_data_i),
    .desc_commit_i(desc_commit_i), .rx_start_i(rx_start),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_end_i(rx_end),
    .rx_for_station_i(rx_for_station_i), .desc_ready_o(desc_ready_o),
    .pattern_match_o(pattern_match_o), .wake_frame_o(wake_frame_o),
    .wake_event_o(wake_event_o));

  frame_source u_frame_source (
    .sys_clk_i(sys_clk_i), .rx_start_o(rx_start), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_end_o(rx_end));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      bad_count++;
    end
  endtask : check

  // Reflected FCS over the picked bytes, final inversion included
  function automatic logic [31:0] fcs();
    logic [31:0] r;
    r = 32'hFFFFFFFF;
    foreach (pick[k]) begin
      for (int i = 0; i < 8; i++) begin
        r = (r[0] ^ pick[k][i]) ? ((r >> 1) ^ 32'hEDB88320) : (r >> 1);
      end
    end
    pick.delete();
    return ~r;
  endfunction : fcs

  task automatic tick;
    @(posedge sys_clk_i);
    #5;
  endtask : tick

  task automatic wr(input logic [7:0] b);
    desc_wr_i = 1'b1;
    desc_data_i = b;
    tick();
  endtask : wr

  task automatic wcrc(input logic [31:0] c);
    for (int i = 0; i < 4; i++) wr(c[8*i +: 8]);
  endtask : wcrc

  ////////////////////////////////////////////////////////////////////////////
  task automatic run(input int gap, input logic [3:0] pm, input logic wf);
    foreach (frm[i]) u_frame_source.push(frm[i]);
    u_frame_source.send(gap);
    check("pattern_match", {28'h0, pm}, {28'h0, pattern_match_o});
    check("wake_frame", {31'h0, wf}, {31'h0, wake_frame_o});
    check("wake_event", {31'h0, |pm | wf}, {31'h0, wake_event_o});
    tick();
    check("pulse end", 32'h0, {26'h0, pattern_match_o, wake_frame_o,
                               wake_event_o});
  endtask : run

  task automatic add_ff(input int n);
    repeat (n) frm.push_back(8'hFF);
  endtask : add_ff

  task automatic add_addr(input int n);
    repeat (n) for (int i = 5; i >= 0; i--) frm.push_back(STATION[8*i +: 8]);
  endtask : add_addr

  initial begin
    repeat (2) @(posedge sys_clk_i);
    #5;
    rstn_i = 1'b1;
    check("reset outputs", 32'h0, {25'h0, desc_ready_o, pattern_match_o,
                                   wake_frame_o, wake_event_o});
    for (int i = 0; i < 10; i++) frm.push_back(8'h07 + 8'(i * 8'h21));
    pick = frm[1:2];
    c0 = fcs();
    pick = frm[3:6];
    c1 = fcs();
    pick = frm[2:6];
    c2 = fcs();
    pick = {frm[4], frm[6]};
    c3 = fcs();
    desc_clear_i = 1'b1;
    tick();
    desc_clear_i = 1'b0;
    wr(8'h12);
    wr(8'h00);
    wcrc(c0);
    wr(8'hFF);
    wr(8'h03);
    wr(8'h04);
    wr(8'h00);
    wcrc(c1);
    wr(8'h2F);
    wr(8'h05);
    wr(8'h00);
    wcrc(c2);
    wr(8'hF1);
    wr(8'h04);
    wr(8'h11);
    wr(8'h00);
    wcrc(c3);
    desc_wr_i = 1'b0;
    desc_commit_i = 1'b1;
    tick();
    desc_commit_i = 1'b0;
    for (int i = 0; i < 200 && desc_ready_o !== 1'b1; i++) tick();
    check("desc_ready", 32'h1, {31'h0, desc_ready_o});
    run(0, 4'hF, 1'b0);
    frm[5] = frm[5] ^ 8'h40;
    run(1, 4'b1001, 1'b0);
    frm = frm[0:3];
    run(1, 4'b0001, 1'b0);
    frm = frm[0:1];
    pattern_en_i = 1'b0;
    wake_frame_en_i = 1'b1;
    frm = {8'h3C, 8'h11};
    add_ff(7);
    add_addr(16);
    frm.push_back(8'h55);
    run(0, 4'h0, 1'b1);
    rx_for_station_i = 1'b0;
    run(0, 4'h0, 1'b0);
    rx_for_station_i = 1'b1;
    wake_frame_en_i = 1'b0;
    run(0, 4'h0, 1'b0);
    wake_frame_en_i = 1'b1;
    frm.delete();
    add_ff(6);
    add_addr(15);
    frm.push_back(8'h3C);
    run(0, 4'h0, 1'b0);
    frm.delete();
    add_ff(5);
    add_addr(16);
    run(0, 4'h0, 1'b0);
    frm.delete();
    add_ff(6);
    add_addr(3);
    frm.push_back(8'h00);
    add_ff(6);
    add_addr(16);
    run(0, 4'h0, 1'b1);
    foreach (frm[i]) u_frame_source.push(frm[i]);
    u_frame_source.send(0);
    ce_i = 1'b0;
    tick();
    check("ce hold", 32'h3, {30'h0, wake_frame_o, wake_event_o});
    ce_i = 1'b1;
    tick();
    check("ce release", 32'h0, {30'h0, wake_frame_o, wake_event_o});
    results();
  end
endmodule : wake_frame_pattern_matcher_tb
